// >>> met_timing.sv
/*
 * Multiply timing interlock: accepts multiplies from the issue stage,
 * tracks issue, result and resource latencies per early-termination
 * class, and stalls dependent consumers and further multiplies.
 * Assumes the issue stage presents one multiply at a time and one
 * dependent consumer query per cycle, all synchronous to clk.
 */
// Behaviour
// - The multiplier operand is classed short when bits 31..15 are all zero or all one, else medium when bits 31..27 are, else full.
// - Multiply-accumulate 32 takes issue/result/resource 1/2/1, 1/3/2, 1/4/3 by class, or 2/2/2, 3/3/3, 4/4/4 when flags update.
// - Multiply 32 takes exactly the latencies of multiply-accumulate 32.
// - Signed long MAC takes issue 2, low/high 2/3, 3/4, 4/5, resource 2, 3, 4, or all three 3, 4, 5 with flags.
// - Signed long multiply takes issue 1, low/high 2/3, 3/4, 4/5, resource 2, 3, 4, or all 3, 4, 5 with flags.
// - Unsigned long MAC times exactly as signed long MAC.
// - Unsigned long multiply times exactly as signed long multiply.
// - Halfword forms skip early termination with their own fixed issue, result and resource latencies.
// - A consumer using the result as an immediate shift operand or first operand of a saturating double add or subtract waits one cycle more.
module met_timing #(
  parameter int LAT_W = met_pkg::LAT_W
) (
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  // Multiply request from the issue stage.
  input  wire logic                 mul_valid,
  input  wire met_pkg::met_op_t     mul_op,
  input  wire logic                 mul_set_flags,
  input  wire logic [31:0]          multiplier_operand,
  output logic                      mul_ready,
  output logic                      issue_hold,
  // Dependent consumer query.
  input  wire logic                 dep_valid,
  input  wire logic                 dep_uses_low,
  input  wire logic                 dep_uses_high,
  input  wire logic                 dep_late_use,
  output logic                      dep_stall,
  // Status of the last accepted multiply.
  output logic                      result_low_ready,
  output logic                      result_high_ready,
  output met_pkg::met_class_t       last_class,
  output logic                      unit_busy
);

  // ==========================================================================
  // Elaboration check.
  if (LAT_W < met_pkg::LAT_W) begin : g_bad_width
    $error("met_timing: LAT_W too narrow for the latency figures");
  end

  // ==========================================================================
  // Latency lookup.
  met_lat_if lat ();

  assign lat.op        = mul_op;
  assign lat.set_flags = mul_set_flags;
  assign lat.operand   = multiplier_operand;

  met_lat_lookup u_lookup (
    .lk (lat.lookup)
  );

  // ==========================================================================
  // Countdown state. Each counter loads its latency when a multiply is
  // taken and counts down to zero; a value of one or less means the plain
  // latency has elapsed, zero means one more cycle has.
  logic [LAT_W-1:0]    cnt_reg  [met_pkg::CNT_N];
  logic [LAT_W-1:0]    load_val [met_pkg::CNT_N];
  logic                mul_take;
  logic                issue_ok;
  logic                res_ok;
  met_pkg::met_class_t class_reg;

  assign load_val[met_pkg::CNT_ISSUE] = LAT_W'(lat.lat_issue);
  assign load_val[met_pkg::CNT_LOW]   = LAT_W'(lat.lat_low);
  assign load_val[met_pkg::CNT_HIGH]  = LAT_W'(lat.lat_high);
  assign load_val[met_pkg::CNT_RES]   = LAT_W'(lat.lat_res);

  genvar gi;
  generate
    for (gi = 0; gi < met_pkg::CNT_N; gi++) begin : g_cnt
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          cnt_reg[gi] <= '0;
        end else if (mul_take) begin
          cnt_reg[gi] <= load_val[gi];
        end else if (cnt_reg[gi] != '0) begin
          cnt_reg[gi] <= cnt_reg[gi] - LAT_W'(met_pkg::LAT_EXTRA);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      class_reg <= met_pkg::cls_short;
    end else if (mul_take) begin
      class_reg <= lat.cls;
    end
  end

  // ==========================================================================
  // Interlocks.
  function automatic logic plain_done(input logic [LAT_W-1:0] c);
    plain_done = (c <= LAT_W'(met_pkg::LAT_EXTRA));
  endfunction : plain_done

  assign issue_ok  = plain_done(cnt_reg[met_pkg::CNT_ISSUE]);
  assign res_ok    = plain_done(cnt_reg[met_pkg::CNT_RES]);
  assign mul_ready = issue_ok && res_ok;
  assign mul_take  = mul_valid && mul_ready;
  assign issue_hold = !issue_ok;

  logic low_wait;
  logic high_wait;

  always_comb begin
    if (dep_late_use) begin
      low_wait  = (cnt_reg[met_pkg::CNT_LOW]  != '0);
      high_wait = (cnt_reg[met_pkg::CNT_HIGH] != '0);
    end else begin
      low_wait  = !plain_done(cnt_reg[met_pkg::CNT_LOW]);
      high_wait = !plain_done(cnt_reg[met_pkg::CNT_HIGH]);
    end
  end

  assign dep_stall = dep_valid
                     && ((dep_uses_low && low_wait)
                         || (dep_uses_high && high_wait));

  // ==========================================================================
  // Status outputs.
  assign result_low_ready  = plain_done(cnt_reg[met_pkg::CNT_LOW]);
  assign result_high_ready = plain_done(cnt_reg[met_pkg::CNT_HIGH]);
  assign last_class        = class_reg;
  assign unit_busy         = !res_ok;

endmodule : met_timing

// >>> met_pkg.sv
/*
 * Shared constants and types of the multiplier timing block: operation
 * codes, early-termination classes, operand field positions and the
 * latency figures in clock cycles.
 * Assumes a single core clock; nothing here holds state.
 */
package met_pkg;

  // ==========================================================================
  // Operations and early-termination classes.
  typedef enum logic [3:0] {
    multiply_32,
    multiply_accumulate_32,
    signed_long_mac,
    signed_long_multiply,
    unsigned_long_mac,
    unsigned_long_multiply,
    halfword_long_mac,
    halfword_mac,
    halfword_multiply,
    word_halfword_mac,
    word_halfword_multiply
  } met_op_t;

  typedef enum logic [1:0] {
    cls_short,
    cls_medium,
    cls_full
  } met_class_t;

  // ==========================================================================
  // Operand geometry.
  localparam int OPND_W        = 32;
  localparam int OPND_MSB      = 31;
  localparam int SHORT_LSB     = 15;
  localparam int MEDIUM_LSB    = 27;

  // ==========================================================================
  // Latency figures in cycles; the class index adds on top of a base.
  localparam int LAT_W         = 3;
  localparam logic [2:0] LAT_ONE   = 3'h1;
  localparam logic [2:0] LAT_TWO   = 3'h2;
  localparam logic [2:0] LAT_THREE = 3'h3;
  localparam logic [2:0] LAT_ZERO  = 3'h0;
  localparam logic [2:0] LAT_EXTRA = 3'h1;

  // Counter index of each tracked latency.
  localparam int CNT_ISSUE     = 0;
  localparam int CNT_LOW       = 1;
  localparam int CNT_HIGH      = 2;
  localparam int CNT_RES       = 3;
  localparam int CNT_N         = 4;

endpackage : met_pkg

// >>> met_lat_if.sv
/*
 * Carrier between the timing core and its latency lookup.
 * Assumes both ends sit in the same clock domain; the lookup is purely
 * combinational.
 */
interface met_lat_if;
  met_pkg::met_op_t        op;
  logic                    set_flags;
  logic [31:0]             operand;
  met_pkg::met_class_t     cls;
  logic [2:0]              lat_issue;
  logic [2:0]              lat_low;
  logic [2:0]              lat_high;
  logic [2:0]              lat_res;

  modport lookup (
    input  op, set_flags, operand,
    output cls, lat_issue, lat_low, lat_high, lat_res
  );
  modport user (
    output op, set_flags, operand,
    input  cls, lat_issue, lat_low, lat_high, lat_res
  );
endinterface : met_lat_if

// >>> met_lat_lookup.sv
/*
 * Latency lookup: classifies the multiplier operand and returns issue,
 * split result and resource latencies for one multiply.
 * Assumes the caller registers whatever it keeps; purely combinational.
 */
module met_lat_lookup (
  met_lat_if.lookup lk
);

  logic [2:0] ofs;
  logic [16:0] upper_short;
  logic [4:0]  upper_medium;

  // ==========================================================================
  // Operand classification.
  assign upper_short  = lk.operand[met_pkg::OPND_MSB:met_pkg::SHORT_LSB];
  assign upper_medium = lk.operand[met_pkg::OPND_MSB:met_pkg::MEDIUM_LSB];

  always_comb begin
    if ((upper_short == '0) || (upper_short == '1)) begin
      lk.cls = met_pkg::cls_short;
    end else if ((upper_medium == '0) || (upper_medium == '1)) begin
      lk.cls = met_pkg::cls_medium;
    end else begin
      lk.cls = met_pkg::cls_full;
    end
  end

  assign ofs = 3'(lk.cls);

  // ==========================================================================
  // Latency table.
  always_comb begin
    lk.lat_issue = met_pkg::LAT_ONE;
    lk.lat_low   = met_pkg::LAT_TWO;
    lk.lat_high  = met_pkg::LAT_TWO;
    lk.lat_res   = met_pkg::LAT_ONE;
    case (lk.op)
      met_pkg::multiply_32,
      met_pkg::multiply_accumulate_32: begin
        lk.lat_low  = met_pkg::LAT_TWO + ofs;
        lk.lat_high = met_pkg::LAT_TWO + ofs;
        if (lk.set_flags) begin
          lk.lat_issue = met_pkg::LAT_TWO + ofs;
          lk.lat_res   = met_pkg::LAT_TWO + ofs;
        end else begin
          lk.lat_issue = met_pkg::LAT_ONE;
          lk.lat_res   = met_pkg::LAT_ONE + ofs;
        end
      end
      met_pkg::signed_long_mac,
      met_pkg::unsigned_long_mac,
      met_pkg::signed_long_multiply,
      met_pkg::unsigned_long_multiply: begin
        if (lk.set_flags) begin
          lk.lat_issue = met_pkg::LAT_THREE + ofs;
          lk.lat_low   = met_pkg::LAT_THREE + ofs;
          lk.lat_high  = met_pkg::LAT_THREE + ofs;
          lk.lat_res   = met_pkg::LAT_THREE + ofs;
        end else begin
          lk.lat_low  = met_pkg::LAT_TWO + ofs;
          lk.lat_high = met_pkg::LAT_THREE + ofs;
          lk.lat_res  = met_pkg::LAT_TWO + ofs;
          if ((lk.op == met_pkg::signed_long_mac)
              || (lk.op == met_pkg::unsigned_long_mac)) begin
            lk.lat_issue = met_pkg::LAT_TWO;
          end else begin
            lk.lat_issue = met_pkg::LAT_ONE;
          end
        end
      end
      met_pkg::halfword_long_mac: begin
        lk.lat_issue = met_pkg::LAT_TWO;
        lk.lat_low   = met_pkg::LAT_TWO;
        lk.lat_high  = met_pkg::LAT_THREE;
        lk.lat_res   = met_pkg::LAT_TWO;
      end
      met_pkg::halfword_mac,
      met_pkg::halfword_multiply: begin
        lk.lat_issue = met_pkg::LAT_ONE;
        lk.lat_low   = met_pkg::LAT_TWO;
        lk.lat_high  = met_pkg::LAT_TWO;
        lk.lat_res   = met_pkg::LAT_ONE;
      end
      met_pkg::word_halfword_mac,
      met_pkg::word_halfword_multiply: begin
        lk.lat_issue = met_pkg::LAT_ONE;
        lk.lat_low   = met_pkg::LAT_THREE;
        lk.lat_high  = met_pkg::LAT_THREE;
        lk.lat_res   = met_pkg::LAT_TWO;
      end
      default: begin
        lk.lat_issue = met_pkg::LAT_ONE;
      end
    endcase
  end

endmodule : met_lat_lookup

// >>> met_timing_props.sv
/* Port checker of the multiply timing interlock.
   Assumes it is bound to met_timing, one clock domain. */
module met_timing_props #(
  parameter int LAT_W = 3
) (
  // Clock and reset.
  input wire logic                clk,
  input wire logic                arst_n,
  // Multiply request.
  input wire logic                mul_valid,
  input wire met_pkg::met_op_t    mul_op,
  input wire logic                mul_set_flags,
  input wire logic [31:0]         multiplier_operand,
  input wire logic                mul_ready,
  input wire logic                issue_hold,
  // Consumer query.
  input wire logic                dep_valid,
  input wire logic                dep_uses_low,
  input wire logic                dep_uses_high,
  input wire logic                dep_late_use,
  input wire logic                dep_stall,
  // Status.
  input wire logic                result_low_ready,
  input wire logic                result_high_ready,
  input wire met_pkg::met_class_t last_class,
  input wire logic                unit_busy
);
  // ==========================================================================
  // Expected class and the take sequence.
  logic [31:0]         opnd;
  met_pkg::met_class_t cls_in;
  assign opnd = multiplier_operand;
  assign cls_in = (&opnd[31:15] || ~|opnd[31:15]) ? met_pkg::cls_short :
                  (&opnd[31:27] || ~|opnd[31:27]) ? met_pkg::cls_medium :
                  met_pkg::cls_full;
  sequence s_take;
    mul_valid && mul_ready;
  endsequence
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ==========================================================================
  // Assertions.
  chk_class_pick: assert property (s_take |=> last_class == $past(cls_in))
    else $error("class of taken operand wrong");
  chk_class_hold: assert property (!(mul_valid && mul_ready) |=> $stable(last_class))
    else $error("class changed without a take");
  chk_flag_issue: assert property ((s_take ##0 (mul_set_flags && mul_op == met_pkg::multiply_32)) |=> issue_hold)
    else $error("flag update issued in one cycle");
  chk_low_wait: assert property (s_take |=> !result_low_ready)
    else $error("result ready one cycle after take");
  chk_issue_end: assert property (s_take |-> ##[1:5] !issue_hold)
    else $error("issue hold too long");
  chk_ready_rule: assert property (mul_ready == (!issue_hold && !unit_busy))
    else $error("ready disagrees with hold and busy");
  chk_high_order: assert property (result_high_ready |-> result_low_ready)
    else $error("high half before low half");
  chk_stall_low: assert property (dep_valid && dep_uses_low && !dep_late_use && !result_low_ready |-> dep_stall)
    else $error("consumer not stalled");
  chk_late_extra: assert property (dep_valid && dep_late_use && dep_uses_high && $rose(result_high_ready) |-> dep_stall)
    else $error("late use missed extra cycle");
  chk_half_fast: assert property ((s_take ##0 (mul_op == met_pkg::halfword_mac)) |=> mul_ready)
    else $error("halfword mac not back to back");
  chk_dep_idle: assert property (!dep_valid |-> !dep_stall)
    else $error("stall without a query");
endmodule : met_timing_props

bind met_timing met_timing_props #(.LAT_W(LAT_W)) u_props (
  .clk(clk), .arst_n(arst_n), .mul_valid(mul_valid), .mul_op(mul_op),
  .mul_set_flags(mul_set_flags), .multiplier_operand(multiplier_operand),
  .mul_ready(mul_ready), .issue_hold(issue_hold), .dep_valid(dep_valid),
  .dep_uses_low(dep_uses_low), .dep_uses_high(dep_uses_high),
  .dep_late_use(dep_late_use), .dep_stall(dep_stall),
  .result_low_ready(result_low_ready), .result_high_ready(result_high_ready),
  .last_class(last_class), .unit_busy(unit_busy)
);

// >>> met_issue_model.sv
/* Issue stage model: presents one multiply and holds it until taken.
   Assumes it is called at a falling edge of clk. */
module met_issue_model (
  // Clock and readiness.
  input  wire logic       clk,
  input  wire logic       mul_ready,
  // Multiply request.
  output logic            mul_valid,
  output met_pkg::met_op_t mul_op,
  output logic            mul_set_flags,
  output logic [31:0]     multiplier_operand
);
  initial begin
    mul_valid = 1'b0;
    mul_op = met_pkg::multiply_32;
    mul_set_flags = 1'b0;
    multiplier_operand = 32'h0000_0000;
  end
  task automatic issue(met_pkg::met_op_t op, logic s, logic [31:0] v,
                       output int w);
    w = 0;
    mul_valid = 1'b1;
    mul_op = op;
    mul_set_flags = s;
    multiplier_operand = v;
    while (mul_ready !== 1'b1 && w < 20) begin
      @(negedge clk);
      w++;
    end
    @(posedge clk);
  endtask : issue
  task automatic idle();
    mul_valid = 1'b0;
    multiplier_operand = ~multiplier_operand;
  endtask : idle
endmodule : met_issue_model

// >>> test_multiplier_early_termination_timing.sv
/* Self-checking bench of the multiply timing interlock.
   Assumes met_timing, its checker and the issue stage model. */
module test_multiplier_early_termination_timing;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk = 1'b0;
  logic                arst_n = 1'b0;
  logic                mul_valid, mul_set_flags, mul_ready, issue_hold;
  met_pkg::met_op_t    mul_op;
  logic [31:0]         multiplier_operand;
  logic                dep_valid = 1'b0, dep_uses_low = 1'b0;
  logic                dep_uses_high = 1'b0, dep_late_use = 1'b0;
  logic                dep_stall, result_low_ready, result_high_ready;
  logic                unit_busy;
  met_pkg::met_class_t last_class;
  int                  mismatches = 0;
  int                  check_count = 0;
  always #2.5 clk = ~clk;
  met_issue_model u_issue (.clk(clk), .mul_ready(mul_ready),
    .mul_valid(mul_valid), .mul_op(mul_op), .mul_set_flags(mul_set_flags),
    .multiplier_operand(multiplier_operand));
  met_timing dut (.clk(clk), .arst_n(arst_n), .mul_valid(mul_valid),
    .mul_op(mul_op), .mul_set_flags(mul_set_flags),
    .multiplier_operand(multiplier_operand), .mul_ready(mul_ready),
    .issue_hold(issue_hold), .dep_valid(dep_valid),
    .dep_uses_low(dep_uses_low), .dep_uses_high(dep_uses_high),
    .dep_late_use(dep_late_use), .dep_stall(dep_stall),
    .result_low_ready(result_low_ready),
    .result_high_ready(result_high_ready), .last_class(last_class),
    .unit_busy(unit_busy));
  // ==========================================================================
  // Shared helpers.
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  function automatic logic [15:0] exp_lat(met_pkg::met_op_t op, logic s,
                                          int c);
    logic [3:0] a, b;
    a = 4'(2 + c);
    b = 4'(3 + c);
    case (op)
      met_pkg::multiply_32, met_pkg::multiply_accumulate_32:
        return s ? {4{a}} : {4'h1, a, a, 4'(1 + c)};
      met_pkg::signed_long_mac, met_pkg::unsigned_long_mac:
        return s ? {4{b}} : {4'h2, a, b, a};
      met_pkg::signed_long_multiply, met_pkg::unsigned_long_multiply:
        return s ? {4{b}} : {4'h1, a, b, a};
      met_pkg::halfword_long_mac: return 16'h2232;
      met_pkg::halfword_mac, met_pkg::halfword_multiply: return 16'h1221;
      default: return 16'h1332;
    endcase
  endfunction : exp_lat
  // ==========================================================================
  // Scenarios.
  task automatic t_forms();
    logic [31:0] tab[6] = '{32'h0000_7FFF, 32'h07FF_FFFF, 32'h8000_0000,
                            32'hFFFF_8000, 32'hF800_0000, 32'h7000_0000};
    logic [15:0] e;
    logic [3:0]  n[6];
    logic        late;
    int          w;
    for (int o = 0; o < 11; o++) begin
      for (int s = 0; s < 2; s++) begin
        for (int c = 0; c < 3; c++) begin
          e = exp_lat(met_pkg::met_op_t'(o), s[0], c);
          late = 1'((o + c) % 2);
          n = '{default: 4'h0};
          dep_valid = 1'b1;
          dep_late_use = late;
          dep_uses_low = !late;
          dep_uses_high = late;
          u_issue.issue(met_pkg::met_op_t'(o), s[0], tab[s*3+c], w);
          check("wait", 32'(w), 32'h0000_0000);
          for (int k = 1; k < 8; k++) begin
            @(negedge clk);
            if (k == 1) u_issue.idle();
            n[0] += 4'(issue_hold !== 1'b0);
            n[1] += 4'(result_low_ready !== 1'b1);
            n[2] += 4'(result_high_ready !== 1'b1);
            n[3] += 4'(unit_busy !== 1'b0);
            n[4] += 4'(mul_ready !== 1'b1);
            n[5] += 4'(dep_stall !== 1'b0);
            if (k == 1) check("class", 32'(last_class), 32'(c));
          end
          check("lat", {n[0], n[1], n[2], n[3]}, 32'(e - 16'h1111));
          check("ready", 32'(n[4]), 32'((e[15:12] > e[3:0] ? e[15:12] : e[3:0]) - 4'h1));
          check("stall", 32'(n[5]), 32'((late ? e[7:4] : e[11:8]) - 4'h1 + 4'(late)));
        end
      end
    end
  endtask : t_forms
  task automatic t_refused();
    int w;
    dep_valid = 1'b0;
    u_issue.issue(met_pkg::signed_long_multiply, 1'b1, 32'h8000_0000, w);
    @(negedge clk);
    dep_valid = 1'b1;
    dep_late_use = 1'b1;
    dep_uses_low = 1'b1;
    dep_uses_high = 1'b0;
    u_issue.issue(met_pkg::halfword_mac, 1'b0, 32'h0000_0001, w);
    check("held", 32'(w), 32'h0000_0004);
    @(negedge clk);
    u_issue.idle();
    check("class", 32'(last_class), 32'(met_pkg::cls_short));
    check("low", 32'(result_low_ready), 32'h0000_0000);
    @(negedge clk);
    check("late low", 32'(dep_stall), 32'h0000_0001);
    check("low ready", 32'(result_low_ready), 32'h0000_0001);
    repeat (3) @(negedge clk);
  endtask : t_refused
  task automatic t_reset();
    int w;
    dep_valid = 1'b1;
    u_issue.issue(met_pkg::signed_long_mac, 1'b0, 32'h8000_0000, w);
    @(negedge clk);
    u_issue.idle();
    arst_n = 1'b0;
    @(negedge clk);
    check("rst", {mul_ready, issue_hold, dep_stall, result_low_ready,
      result_high_ready, unit_busy, last_class}, 32'h0000_0098);
    arst_n = 1'b1;
    @(negedge clk);
    u_issue.issue(met_pkg::halfword_multiply, 1'b0, 32'h0000_0001, w);
    check("rst wait", 32'(w), 32'h0000_0000);
    @(negedge clk);
    u_issue.idle();
    check("rst low", 32'(result_low_ready), 32'h0000_0000);
    check("rst ready", 32'(mul_ready), 32'h0000_0001);
    repeat (2) @(negedge clk);
  endtask : t_reset
  // ==========================================================================
  // Sequence, watchdog and verdict.
  task automatic test_done();
    if (mismatches == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    t_forms();
    t_refused();
    t_reset();
    test_done();
  end
  initial begin
    #20000;
    mismatches++;
    test_done();
  end
endmodule : test_multiplier_early_termination_timing
